// file: csif_pkg.sv
// csif_pkg: constants and types of the cpu status and interrupt flag bank
package csif_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_INTCTL = 8'h8b;
  localparam logic [7:0] IDX_PIE    = 8'h8c;
  localparam logic [7:0] IDX_PIR    = 8'h0c;
  localparam logic [7:0] IDX_EVSTS  = 8'ha0;
  localparam logic [7:0] IDX_EVMSK  = 8'ha1;
  // status bit positions
  localparam int ST_C    = 0;
  localparam int ST_DC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_PD   = 3;
  localparam int ST_TO   = 4;
  localparam int ST_BANK = 5;
  localparam logic [7:0] STATUS_RST   = 8'h18;
  localparam logic [7:0] STATUS_WMASK = 8'he7;
  localparam logic [7:0] OPT_RST      = 8'h00;
  localparam logic [7:0] OPT_WMASK    = 8'hbf;
  localparam int         OPT_PSA      = 3;
  // interrupt control bit positions
  localparam int IC_GIE  = 7;
  localparam int IC_PEIE = 6;
  localparam int IC_TOIE = 5;
  localparam int IC_TIMER_OVERFLOW_FLAG = 2;
  localparam logic [7:0] INT_WMASK = 8'he4;
  localparam logic [7:0] PIE_MASK  = 8'h9f;
  localparam int         BANK_SPAN = 128;
  // block event bits
  localparam int EV_TMR = 0;
  localparam int EV_PER = 1;
  localparam int EV_WDT = 2;
  localparam int EV_SLP = 3;

  typedef enum logic [8:0] {
    OP_ADD  = 9'h001,
    OP_SUB  = 9'h002,
    OP_AND  = 9'h004,
    OP_IOR  = 9'h008,
    OP_XOR  = 9'h010,
    OP_CLR  = 9'h020,
    OP_RLF  = 9'h040,
    OP_RRF  = 9'h080,
    OP_MOVW = 9'h100
  } csif_op_t;

  typedef struct packed {
    logic       valid;
    csif_op_t   op;
    logic [7:0] opA;
    logic [7:0] opB;
    logic       toStatus;
  } csif_alu_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] result;
  } csif_alu_rsp_t;

  typedef struct packed {
    logic [7:0]    status;
    logic [7:0]    option;
    logic [7:0]    intctl;
    logic [7:0]    pie;
    logic [7:0]    pir;
    logic [3:0]    evSts;
    logic [3:0]    evMsk;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    csif_alu_rsp_t aluRsp;
    logic [7:0]    physAddr;
    logic          intReq;
    logic          irq;
  } csif_state_t;
endpackage

// file: csif_status_bank.sv
// csif_status_bank: cpu status register and interrupt flag bank on APB
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module csif_status_bank (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic [11:0]            paddr,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output wire logic [31:0]            prdata,
  output wire logic                   pready,
  output wire logic                   pslverr,
  input  wire csif_pkg::csif_alu_req_t aluReq,
  output wire csif_pkg::csif_alu_rsp_t aluRsp,
  input  wire logic [6:0]             dirAddr,
  output wire logic [7:0]             physAddr,
  input  wire logic                   clear_watchdog_instr,
  input  wire logic                   sleepCmd,
  input  wire logic                   wdtTimeout,
  input  wire logic                   tmrOverflow,
  input  wire logic [7:0]             periphEvt,
  output wire logic [7:0]             statusOut,
  output wire logic [7:0]             optionOut,
  output wire logic                   bypassPrescale,
  output wire logic                   intReq,
  output wire logic                   irq
);

  csif_pkg::csif_state_t state_reg;
  csif_pkg::csif_state_t state_next;
  logic                  apbAcc;
  logic                  apbDone;
  logic                  wrEn;
  logic                  rdDone;
  logic                  hit;
  logic [7:0]            rdMux;
  logic [8:0]            sum9;
  logic [4:0]            sum5;
  logic [7:0]            aluRes;
  logic                  zNew;
  logic                  cNew;
  logic                  dcNew;
  logic                  updZ;
  logic                  updC;
  logic                  updDc;
  logic [3:0]            evIn;

  function automatic logic csif_sel(input logic [11:0] a,
                                    input logic [7:0]  idx);
    csif_sel = (a == {2'b00, idx, 2'b00});
  endfunction

  assign apbAcc  = psel & penable;
  assign apbDone = apbAcc & state_reg.pready;
  assign wrEn    = apbDone & pwrite & pstrb[0] & ~state_reg.pslverr;
  assign rdDone  = apbDone & ~pwrite;
  assign evIn    = {sleepCmd, wdtTimeout,
                    |(periphEvt & csif_pkg::PIE_MASK), tmrOverflow};

  always_comb begin
    hit   = 1'b1;
    rdMux = 8'h00;
    if (csif_sel(paddr, csif_pkg::IDX_STATUS)) begin
      rdMux = state_reg.status;
    end else if (csif_sel(paddr, csif_pkg::IDX_OPTION)) begin
      rdMux = state_reg.option;
    end else if (csif_sel(paddr, csif_pkg::IDX_INTCTL)) begin
      rdMux = state_reg.intctl;
    end else if (csif_sel(paddr, csif_pkg::IDX_PIE)) begin
      rdMux = state_reg.pie;
    end else if (csif_sel(paddr, csif_pkg::IDX_PIR)) begin
      rdMux = state_reg.pir;
    end else if (csif_sel(paddr, csif_pkg::IDX_EVSTS)) begin
      rdMux = {4'h0, state_reg.evSts};
    end else if (csif_sel(paddr, csif_pkg::IDX_EVMSK)) begin
      rdMux = {4'h0, state_reg.evMsk};
    end else begin
      hit = 1'b0;
    end
  end

  // alu result and flag outcome
  always_comb begin
    sum9   = 9'h000;
    sum5   = 5'h00;
    aluRes = aluReq.opA;
    cNew   = state_reg.status[csif_pkg::ST_C];
    dcNew  = state_reg.status[csif_pkg::ST_DC];
    updZ   = 1'b0;
    updC   = 1'b0;
    updDc  = 1'b0;
    case (aluReq.op)
      csif_pkg::OP_ADD: begin
        sum9   = {1'b0, aluReq.opA} + {1'b0, aluReq.opB};
        sum5   = {1'b0, aluReq.opA[3:0]} + {1'b0, aluReq.opB[3:0]};
        aluRes = sum9[7:0];
        cNew   = sum9[8];
        dcNew  = sum5[4];
        updZ   = 1'b1;
        updC   = 1'b1;
        updDc  = 1'b1;
      end
      csif_pkg::OP_SUB: begin
        // two's complement add, so carry reads as not-borrow
        sum9   = {1'b0, aluReq.opA} + {1'b0, ~aluReq.opB} + 9'h001;
        sum5   = {1'b0, aluReq.opA[3:0]} + {1'b0, ~aluReq.opB[3:0]}
                 + 5'h01;
        aluRes = sum9[7:0];
        cNew   = sum9[8];
        dcNew  = sum5[4];
        updZ   = 1'b1;
        updC   = 1'b1;
        updDc  = 1'b1;
      end
      csif_pkg::OP_AND: begin
        aluRes = aluReq.opA & aluReq.opB;
        updZ   = 1'b1;
      end
      csif_pkg::OP_IOR: begin
        aluRes = aluReq.opA | aluReq.opB;
        updZ   = 1'b1;
      end
      csif_pkg::OP_XOR: begin
        aluRes = aluReq.opA ^ aluReq.opB;
        updZ   = 1'b1;
      end
      csif_pkg::OP_CLR: begin
        aluRes = 8'h00;
        updZ   = 1'b1;
      end
      csif_pkg::OP_RLF: begin
        aluRes = {aluReq.opA[6:0], state_reg.status[csif_pkg::ST_C]};
        cNew   = aluReq.opA[7];
        updC   = 1'b1;
      end
      csif_pkg::OP_RRF: begin
        aluRes = {state_reg.status[csif_pkg::ST_C], aluReq.opA[7:1]};
        cNew   = aluReq.opA[0];
        updC   = 1'b1;
      end
      default: begin
        aluRes = aluReq.opA;
      end
    endcase
    zNew = (aluRes == 8'h00);
  end

  always_comb begin
    state_next         = state_reg;
    state_next.pready  = apbAcc & ~state_reg.pready;
    state_next.pslverr = apbAcc & ~state_reg.pready & ~hit;
    if (apbAcc & ~state_reg.pready) begin
      state_next.prdata = {24'h000000, rdMux};
    end
    // register writes, time-out and power-down masked off
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_STATUS)) begin
      state_next.status = (state_reg.status & ~csif_pkg::STATUS_WMASK)
                        | (pwdata[7:0] & csif_pkg::STATUS_WMASK);
    end
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_OPTION)) begin
      state_next.option = pwdata[7:0] & csif_pkg::OPT_WMASK;
    end
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_INTCTL)) begin
      state_next.intctl = pwdata[7:0] & csif_pkg::INT_WMASK;
    end
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_PIE)) begin
      state_next.pie = pwdata[7:0] & csif_pkg::PIE_MASK;
    end
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_PIR)) begin
      state_next.pir = pwdata[7:0] & csif_pkg::PIE_MASK;
    end
    if (wrEn & csif_sel(paddr, csif_pkg::IDX_EVMSK)) begin
      state_next.evMsk = pwdata[3:0];
    end
    // only bits actually returned are cleared, later events survive
    if (rdDone & csif_sel(paddr, csif_pkg::IDX_EVSTS)) begin
      state_next.evSts = state_reg.evSts & ~state_reg.prdata[3:0];
    end
    state_next.evSts = state_next.evSts | evIn;
    // alu lands after the bus write, so it wins on a collision
    state_next.aluRsp.valid = aluReq.valid;
    if (aluReq.valid) begin
      state_next.aluRsp.result = aluRes;
      if (aluReq.toStatus & ~(updZ | updC | updDc)) begin
        state_next.status = (state_next.status & ~csif_pkg::STATUS_WMASK)
                          | (aluRes & csif_pkg::STATUS_WMASK);
      end else if (aluReq.toStatus) begin
        // data write to Z, DC, C blocked, so untouched flags keep value
        state_next.status[7:5] = aluRes[7:5];
      end
      if (updZ) begin
        state_next.status[csif_pkg::ST_Z] = zNew;
      end
      if (updC) begin
        state_next.status[csif_pkg::ST_C] = cNew;
      end
      if (updDc) begin
        state_next.status[csif_pkg::ST_DC] = dcNew;
      end
    end
    // watchdog time-out overrides a same-cycle sleep or clear
    if (clear_watchdog_instr) begin
      state_next.status[csif_pkg::ST_TO] = 1'b1;
      state_next.status[csif_pkg::ST_PD] = 1'b1;
    end
    if (sleepCmd) begin
      state_next.status[csif_pkg::ST_TO] = 1'b1;
      state_next.status[csif_pkg::ST_PD] = 1'b0;
    end
    if (wdtTimeout) begin
      state_next.status[csif_pkg::ST_TO] = 1'b0;
    end
    // flags set whatever the enables say; set beats a clearing write
    if (tmrOverflow) begin
      state_next.intctl[csif_pkg::IC_TIMER_OVERFLOW_FLAG] = 1'b1;
    end
    state_next.pir = state_next.pir
                   | (periphEvt & csif_pkg::PIE_MASK);
    state_next.intReq = state_reg.intctl[csif_pkg::IC_GIE]
      & ((state_reg.intctl[csif_pkg::IC_TOIE]
          & state_reg.intctl[csif_pkg::IC_TIMER_OVERFLOW_FLAG])
       | (state_reg.intctl[csif_pkg::IC_PEIE]
          & |(state_reg.pie & state_reg.pir)));
    state_next.irq = |(state_reg.evSts & state_reg.evMsk);
    state_next.physAddr = {state_reg.status[csif_pkg::ST_BANK],
                           dirAddr};
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg        <= '0;
      state_reg.status <= csif_pkg::STATUS_RST;
      state_reg.option <= csif_pkg::OPT_RST;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign prdata    = state_reg.prdata;
  assign pready    = state_reg.pready;
  assign pslverr   = state_reg.pslverr;
  assign aluRsp    = state_reg.aluRsp;
  assign physAddr  = state_reg.physAddr;
  assign statusOut = state_reg.status;
  assign optionOut = state_reg.option;
  // watchdog owning the prescaler means the timer counts 1:1
  assign bypassPrescale = state_reg.option[csif_pkg::OPT_PSA];
  assign intReq    = state_reg.intReq;
  assign irq       = state_reg.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  chk_flags_readonly: assert property (
    ce && wrEn && csif_sel(paddr, csif_pkg::IDX_STATUS)
    && !clear_watchdog_instr && !sleepCmd && !wdtTimeout
    |=> statusOut[4:3] == $past(statusOut[4:3]))
    else $error("status write changed time-out or power-down");

  chk_timeout_clear: assert property (
    ce && wdtTimeout |=> !statusOut[csif_pkg::ST_TO])
    else $error("time-out flag not cleared on watchdog time-out");

  chk_sleep_flags: assert property (
    ce && sleepCmd && !wdtTimeout
    |=> statusOut[csif_pkg::ST_TO] && !statusOut[csif_pkg::ST_PD])
    else $error("sleep did not set time-out and clear power-down");

  chk_clear_watchdog_instr_flags: assert property (
    ce && clear_watchdog_instr && !sleepCmd && !wdtTimeout
    |=> statusOut[4:3] == 2'b11)
    else $error("clear-watchdog did not set both flags");

  chk_clear_status: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_CLR
    && aluReq.toStatus
    |=> statusOut[7:5] == 3'b000 && statusOut[csif_pkg::ST_Z]
        && statusOut[1:0] == $past(statusOut[1:0]))
    else $error("clear of status gave wrong pattern");

  chk_zero_flag: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_XOR
    && !aluReq.toStatus
    |=> statusOut[csif_pkg::ST_Z]
        == ($past(aluReq.opA) == $past(aluReq.opB)))
    else $error("zero flag wrong after logic op");

  chk_add_carry: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_ADD
    |=> statusOut[csif_pkg::ST_C]
        == ($past(aluReq.opA) > ~$past(aluReq.opB)))
    else $error("carry wrong after add");

  chk_sub_borrow: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_SUB
    |=> statusOut[csif_pkg::ST_DC]
        == ($past(aluReq.opA[3:0]) >= $past(aluReq.opB[3:0])))
    else $error("digit borrow wrong after subtract");

  chk_write_blocked: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_AND
    && aluReq.toStatus && (aluReq.opA & aluReq.opB) != 8'h00
    |=> !statusOut[csif_pkg::ST_Z])
    else $error("result bit overrode zero flag");

  chk_rotate_carry: assert property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_RLF
    |=> statusOut[csif_pkg::ST_C] == $past(aluReq.opA[7]))
    else $error("rotate left did not load carry from bit 7");

  chk_bank_page: assert property (
    ce ##1 ce |=> physAddr
      == {$past(statusOut[csif_pkg::ST_BANK]), $past(dirAddr)})
    else $error("direct address page does not follow bank select");

  chk_option_rw: assert property (
    ce && wrEn && csif_sel(paddr, csif_pkg::IDX_OPTION)
    |=> optionOut == ($past(pwdata[7:0]) & csif_pkg::OPT_WMASK))
    else $error("option register write not stored");

  chk_tmr_sticky: assert property (
    ce && tmrOverflow |=> state_reg.intctl[csif_pkg::IC_TIMER_OVERFLOW_FLAG])
    else $error("timer overflow flag not set");

  chk_pir_sticky: assert property (
    ce && periphEvt[0] |=> state_reg.pir[0])
    else $error("peripheral flag not set by its event");

  chk_periph_gate: assert property (
    ce && !state_reg.intctl[csif_pkg::IC_PEIE]
    && !state_reg.intctl[csif_pkg::IC_TIMER_OVERFLOW_FLAG] |=> !intReq)
    else $error("peripheral request without peripheral enable");

  chk_global_gate: assert property (
    ce && !state_reg.intctl[csif_pkg::IC_GIE] |=> !intReq)
    else $error("request raised without global enable");

  chk_pie_layout: assert property (
    (state_reg.pie & ~csif_pkg::PIE_MASK) == 8'h00)
    else $error("unimplemented enable bit set");

  cov_clear_status: cover property (
    ce && aluReq.valid && aluReq.op == csif_pkg::OP_CLR
    && aluReq.toStatus);
  cov_wdt_timeout: cover property (ce && wdtTimeout ##1 !wdtTimeout);
  cov_periph_req: cover property ($rose(intReq));
  cov_irq_read: cover property ($rose(irq) ##[1:20] rdDone);

endmodule

// file: csif_cpu_model.sv
// csif_cpu_model: stand-in for the cpu execution unit facing the bank
`timescale 1ns/1ps
module csif_cpu_model (
  input  wire logic               clk_sys,
  output csif_pkg::csif_alu_req_t aluReq,
  output logic                    clear_watchdog_instr,
  output logic                    sleepCmd,
  output logic                    wdtTimeout,
  output logic                    tmrOverflow,
  output logic [7:0]              periphEvt
);
  initial begin
    aluReq = '0;
    aluReq.op = csif_pkg::OP_MOVW;
    {tmrOverflow, clear_watchdog_instr, sleepCmd, wdtTimeout} = 4'h0;
    periphEvt = 8'h00;
  end

  // operands scrambled once valid drops, so stale data never looks sane
  task automatic do_op(input csif_pkg::csif_op_t op, input logic [7:0] a,
                       input logic [7:0] b, input logic t);
    @(posedge clk_sys);
    aluReq <= '{1'b1, op, a, b, t};
    @(posedge clk_sys);
    aluReq <= '{1'b0, op, ~a, ~b, ~t};
  endtask

  // ev order: timer overflow, clear watchdog, sleep, watchdog time-out
  task automatic pulse(input logic [3:0] ev, input logic [7:0] pe);
    @(posedge clk_sys);
    {tmrOverflow, clear_watchdog_instr, sleepCmd, wdtTimeout} <= ev;
    periphEvt <= pe;
    @(posedge clk_sys);
    {tmrOverflow, clear_watchdog_instr, sleepCmd, wdtTimeout} <= 4'h0;
    periphEvt <= 8'h00;
  endtask
endmodule

// file: cpu_status_and_interrupt_flags_tb_top.sv
// cpu_status_and_interrupt_flags_tb_top: self-checking bench of the bank
`timescale 1ns/1ps
module cpu_status_and_interrupt_flags_tb_top;
  localparam logic [11:0] A_OPT = {2'b00, csif_pkg::IDX_OPTION, 2'b00};
  localparam logic [11:0] A_ST  = {2'b00, csif_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_IC  = {2'b00, csif_pkg::IDX_INTCTL, 2'b00};
  localparam logic [11:0] A_PIE = {2'b00, csif_pkg::IDX_PIE, 2'b00};
  localparam logic [11:0] A_PIR = {2'b00, csif_pkg::IDX_PIR, 2'b00};
  localparam logic [11:0] A_EVS = {2'b00, csif_pkg::IDX_EVSTS, 2'b00};
  localparam logic [11:0] A_EVM = {2'b00, csif_pkg::IDX_EVMSK, 2'b00};
  localparam logic [11:0] A_BAD = 12'h3fc;
  logic                    clk_sys = 1'b0;
  logic                    rstn = 1'b0;
  logic                    ce = 1'b1;
  logic                    psel = 1'b0;
  logic                    penable = 1'b0;
  logic                    pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0;
  logic [6:0]              dirAddr = 7'h05;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  csif_pkg::csif_alu_req_t aluReq;
  csif_pkg::csif_alu_rsp_t aluRsp;
  logic [7:0]              physAddr;
  logic [7:0]              statusOut;
  logic [7:0]              optionOut;
  logic                    bypassPrescale;
  logic                    intReq;
  logic                    irq;
  logic                    clear_watchdog_instr;
  logic                    sleepCmd;
  logic                    wdtTimeout;
  logic                    tmrOverflow;
  logic [7:0]              periphEvt;
  int                      failCount = 0;
  int                      samplesChecked = 0;
  logic [7:0]              expSt;
  logic [31:0]             rd;
  logic                    err;

  always #25 clk_sys = ~clk_sys;

  csif_status_bank u_csif_status_bank (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .psel(psel),
    .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aluReq(aluReq), .aluRsp(aluRsp), .dirAddr(dirAddr),
    .physAddr(physAddr), .clear_watchdog_instr(clear_watchdog_instr), .sleepCmd(sleepCmd),
    .wdtTimeout(wdtTimeout), .tmrOverflow(tmrOverflow),
    .periphEvt(periphEvt), .statusOut(statusOut), .optionOut(optionOut),
    .bypassPrescale(bypassPrescale), .intReq(intReq), .irq(irq)
  );

  csif_cpu_model u_csif_cpu_model (
    .clk_sys(clk_sys), .aluReq(aluReq), .clear_watchdog_instr(clear_watchdog_instr),
    .sleepCmd(sleepCmd), .wdtTimeout(wdtTimeout),
    .tmrOverflow(tmrOverflow), .periphEvt(periphEvt)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failCount++;
      $display("[ERR] pready expected 1 seen 0");
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    check(name, rd, exp);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // returns {result, next status}; op is one-hot, so bits pick the class
  function automatic logic [15:0] alu_exp(csif_pkg::csif_op_t op,
      logic [7:0] a, logic [7:0] b, logic [7:0] s, logic t);
    logic       sub;
    logic [8:0] sum;
    logic [4:0] dig;
    logic [7:0] r;
    logic [7:0] n;
    logic [2:0] m;
    logic       cc;
    sub = op[1];
    sum = {1'b0, a} + {1'b0, sub ? ~b : b} + {8'h00, sub};
    dig = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + {4'h0, sub};
    m = op[1:0] != 0 ? 3'b111 : op[7:6] != 0 ? 3'b001 : {~op[8], 2'b00};
    cc = op[6] ? a[7] : op[7] ? a[0] : sum[8];
    case (op)
      csif_pkg::OP_AND: r = a & b;
      csif_pkg::OP_IOR: r = a | b;
      csif_pkg::OP_XOR: r = a ^ b;
      csif_pkg::OP_CLR: r = 8'h00;
      csif_pkg::OP_RLF: r = {a[6:0], s[0]};
      csif_pkg::OP_RRF: r = {s[0], a[7:1]};
      csif_pkg::OP_MOVW: r = a;
      default: r = sum[7:0];
    endcase
    n = t ? {r[7:5], s[4:3], (m != 3'b000) ? s[2:0] : r[2:0]} : s;
    n[2:0] = (n[2:0] & ~m) | ({r == 8'h00, dig[4], cc} & m);
    return {r, n};
  endfunction

  task automatic alu_one(input csif_pkg::csif_op_t op, input logic [7:0] a,
                         input logic [7:0] b, input logic t);
    logic [15:0] ex;
    ex = alu_exp(op, a, b, expSt, t);
    u_csif_cpu_model.do_op(op, a, b, t);
    @(negedge clk_sys);
    check("aluRsp", {23'h0, aluRsp}, {23'h1, ex[15:8]});
    check("statusOut", {24'h0, statusOut}, {24'h0, ex[7:0]});
    expSt = ex[7:0];
  endtask

  task automatic t_reset();
    @(negedge clk_sys);
    check("statusOut", {24'h0, statusOut}, 32'h18);
    rdchk("status", A_ST, 32'h18);
    rdchk("option", A_OPT, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_option();
    wr(A_OPT, 32'hff);
    rdchk("option", A_OPT, 32'hbf);
    check("bypass", {31'h0, bypassPrescale}, 32'h1);
    check("optionOut", {24'h0, optionOut}, 32'hbf);
    wr(A_OPT, 32'h00);
    settle(0);
    check("bypass", {31'h0, bypassPrescale}, 32'h0);
    $display("test option done");
  endtask

  task automatic t_status();
    wr(A_ST, 32'h00);
    rdchk("status", A_ST, 32'h18);
    wr(A_ST, 32'h20);
    settle(1);
    check("physAddr", {24'h0, physAddr}, 32'h85);
    wr(A_ST, 32'h00);
    settle(1);
    check("physAddr", {24'h0, physAddr}, 32'h05);
    expSt = 8'h18;
    $display("test status done");
  endtask

  task automatic t_alu();
    logic [3:0] kk [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 0, 1};
    logic [7:0] va [11] = '{8'h0f, 8'h10, 8'hf0, 8'h00, 8'h5a, 8'h11,
                            8'h81, 8'h01, 8'h3c, 8'hf0, 8'h00};
    logic [7:0] vb [11] = '{8'h01, 8'h01, 8'h0f, 8'h00, 8'h0f, 8'h22,
                            8'h00, 8'h00, 8'h00, 8'h10, 8'h01};
    for (int i = 0; i < 11; i++) begin
      alu_one(csif_pkg::csif_op_t'(9'h001 << kk[i]), va[i], vb[i], 1'b0);
    end
    alu_one(csif_pkg::OP_ADD, 8'h29, 8'hf8, 1'b1);
    alu_one(csif_pkg::OP_CLR, 8'h00, 8'h00, 1'b1);
    $display("test alu done");
  endtask

  task automatic t_events();
    u_csif_cpu_model.pulse(4'h1, 8'h00);
    @(negedge clk_sys);
    expSt[csif_pkg::ST_TO] = 1'b0;
    check("statusOut", {24'h0, statusOut}, {24'h0, expSt});
    u_csif_cpu_model.pulse(4'h4, 8'h00);
    @(negedge clk_sys);
    expSt = expSt | 8'h18;
    check("statusOut", {24'h0, statusOut}, {24'h0, expSt});
    u_csif_cpu_model.pulse(4'h2, 8'h00);
    @(negedge clk_sys);
    expSt[csif_pkg::ST_PD] = 1'b0;
    check("statusOut", {24'h0, statusOut}, {24'h0, expSt});
    wr(A_ST, {24'h0, expSt | 8'h08});
    rdchk("status", A_ST, {24'h0, expSt});
    $display("test events done");
  endtask

  // ce low must freeze status even across a sleep pulse
  task automatic t_hold();
    @(posedge clk_sys);
    ce <= 1'b0;
    u_csif_cpu_model.pulse(4'h2, 8'h00);
    @(negedge clk_sys);
    check("statusOut", {24'h0, statusOut}, {24'h0, expSt});
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("test hold done");
  endtask

  task automatic t_irq();
    rdchk("evSts", A_EVS, 32'hc);
    wr(A_EVM, 32'h1);
    u_csif_cpu_model.pulse(4'h0, 8'h01);
    settle(1);
    check("irq", {31'h0, irq}, 32'h0);
    u_csif_cpu_model.pulse(4'h8, 8'h00);
    settle(1);
    check("irq", {31'h0, irq}, 32'h1);
    rdchk("evSts", A_EVS, 32'h3);
    settle(1);
    check("irq", {31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask

  task automatic t_intreq();
    wr(A_IC, 32'h00);
    wr(A_PIR, 32'h00);
    u_csif_cpu_model.pulse(4'h8, 8'h00);
    rdchk("intctl", A_IC, 32'h04);
    check("intReq", {31'h0, intReq}, 32'h0);
    wr(A_IC, 32'ha4);
    settle(1);
    check("intReq", {31'h0, intReq}, 32'h1);
    wr(A_IC, 32'h80);
    wr(A_PIE, 32'hff);
    rdchk("pie", A_PIE, 32'h9f);
    u_csif_cpu_model.pulse(4'h0, 8'hff);
    rdchk("pir", A_PIR, 32'h9f);
    check("intReq", {31'h0, intReq}, 32'h0);
    wr(A_IC, 32'hc0);
    settle(1);
    check("intReq", {31'h0, intReq}, 32'h1);
    wr(A_PIR, 32'h00);
    settle(1);
    check("intReq", {31'h0, intReq}, 32'h0);
    apb(1'b0, A_BAD, 32'h0, rd, err);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test intreq done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_option();
    t_status();
    t_alu();
    t_events();
    t_hold();
    t_irq();
    t_intreq();
    summarize();
  end
endmodule
